// *** src/ich_channel.sv ***
// channel end of the peripheral handshake: strobes, direction levels, parity, events
`timescale 1ns/1ps
// Notes on behaviour
// R1 - twelve shared data lines, direction per transfer
// R2 - select and command codes use data lines
// R3 - every word carries an odd parity bit
// R4 - read or write level held whole operation
// R5 - select strobe until accept or refuse
// R6 - command strobe until accept or refuse
// R7 - transfer request level, dropped on accept
// R8 - input request only when word can land
// R9 - output request only after data driven
// R10 - global init zeroes channel, breaks connection
// R11 - host active high while computer runs
// R12 - equipment accepts only requests, drops after
// R13 - equipment connects then accepts select
// R14 - equipment starts command then accepts
// R15 - equipment accepts after placing input word
// R16 - equipment accepts after sampling output word
// R17 - equipment refuses select or command it cannot
// R18 - equipment flags block end on input
// R19 - parity failure when ones count even
// R20 - equipment reports twelve status lines
// R21 - up to eight units, one interrupt each
// R22 - no new strobe until acks low
// R23 - refusal, block end, parity recorded, clearable
module ich_channel #(
  parameter int DATA_W = ich_pkg::DATA_W,
  parameter int STAT_W = ich_pkg::STAT_W,
  parameter int UNITS = ich_pkg::MAX_UNITS
) (
  input wire logic ref_clk, // 50 MHz system clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic computer_run, // computer is operating
  input wire logic global_init_req, // request for a channel-wide initialisation
  input wire logic req_valid, // user request present
  output logic req_ready, // request taken this cycle
  input wire logic [1:0] req_op, // select, command, read or write
  input wire logic [DATA_W-1:0] req_word, // code or output word
  output logic rsp_valid, // one-cycle end of request
  output logic rsp_accepted, // accept seen
  output logic rsp_refused, // refuse seen
  output logic rsp_block_done, // block end seen on input
  output logic [DATA_W-1:0] rsp_word, // word taken in
  output logic rsp_parity_bad, // input word had even ones, or equipment flagged a parity failure on input; output words never set it
  output logic [2:0] event_status, // sticky refuse, block end, parity
  input wire logic [2:0] event_clear, // clear sticky events
  output logic [STAT_W-1:0] unit_status, // synchronised status lines
  output logic [UNITS-1:0] unit_irq, // synchronised interrupt lines
  input wire logic [DATA_W-1:0] data_in, // data lines from equipment
  output logic [DATA_W-1:0] data_out, // data lines to equipment
  output logic data_oe, // channel drives data lines
  input wire logic parity_in, // parity line from equipment
  output logic parity_out, // parity line to equipment
  output logic parity_oe, // channel drives parity line
  output logic read_level, // input operation level
  output logic write_level, // output operation level
  output logic select_unit_strobe, // unit-select code valid
  output logic command_strobe, // command code valid
  output logic word_transfer_request, // word transfer level
  output logic channel_global_init, // init level to equipment
  output logic host_active, // computer running level
  input wire logic accept_ack, // equipment accepts
  input wire logic refuse_ack, // equipment refuses
  input wire logic block_done_flag, // end of data block
  input wire logic odd_check_fail, // equipment parity failure
  input wire logic [STAT_W-1:0] status_lines, // equipment condition
  input wire logic [UNITS-1:0] irq_lines // per-unit interrupts
);
  localparam int SYNC_W = DATA_W + 5 + STAT_W + UNITS;

  initial begin
    if (DATA_W != ich_pkg::DATA_W || UNITS < 1 || UNITS > ich_pkg::MAX_UNITS || STAT_W < 1) begin
      $error("ich_channel: unsupported parameter values");
    end
  end

  // odd parity bit for a word: makes total ones odd
  function automatic logic odd_bit(input logic [DATA_W-1:0] w);
    odd_bit = ~(^w);
  endfunction

  ich_pkg::ich_state_t state_reg;
  ich_pkg::ich_op_t op_reg;
  logic [DATA_W-1:0] word_reg;
  logic [SYNC_W-1:0] sync_bus;
  logic [DATA_W-1:0] s_data;
  logic s_par;
  logic s_acc;
  logic s_ref;
  logic s_done;
  logic s_fail;
  logic init_reg;
  logic xfer_in;
  logic acks_low;
  logic word_bad;
  logic [2:0] event_set;

  // all pin inputs pass two flops before use
  ich_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .async_in({data_in, parity_in, accept_ack, refuse_ack, block_done_flag, odd_check_fail, status_lines, irq_lines}),
    .sync_out(sync_bus)
  );

  assign {s_data, s_par, s_acc, s_ref, s_done, s_fail, unit_status, unit_irq} = sync_bus; // R21
  // a block end left standing would end the next read at once, so it must fall too
  assign acks_low = !s_acc && !s_ref && !s_done;
  assign xfer_in = (op_reg == ich_pkg::ICH_OP_READ);
  assign word_bad = (^{s_data, s_par}) == 1'b0; // R19
  assign req_ready = (state_reg == ich_pkg::ICH_IDLE) && acks_low && !init_reg && req_valid; // R22

  // init level: follows the request one cycle later, set by reset, zeroes channel state
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      init_reg <= 1'b1;
    end else begin
      init_reg <= global_init_req; // R10
    end
  end

  // handshake sequencer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ich_pkg::ICH_IDLE;
      op_reg <= ich_pkg::ICH_OP_SELECT;
      word_reg <= ich_pkg::WORD_ZERO;
    end else if (init_reg) begin
      state_reg <= ich_pkg::ICH_IDLE; // R10
      op_reg <= ich_pkg::ICH_OP_SELECT;
      word_reg <= ich_pkg::WORD_ZERO;
    end else begin
      case (state_reg)
        ich_pkg::ICH_IDLE: begin
          if (req_ready) begin
            op_reg <= ich_pkg::ich_op_t'(req_op);
            word_reg <= req_word; // R2
            case (ich_pkg::ich_op_t'(req_op))
              ich_pkg::ICH_OP_SELECT: state_reg <= ich_pkg::ICH_SELECT;
              ich_pkg::ICH_OP_COMMAND: state_reg <= ich_pkg::ICH_COMMAND;
              default: state_reg <= ich_pkg::ICH_XFER;
            endcase
          end
        end
        ich_pkg::ICH_SELECT, ich_pkg::ICH_COMMAND: begin
          if (s_acc || s_ref) begin
            state_reg <= ich_pkg::ICH_WAIT_LOW; // R5 R6
          end
        end
        ich_pkg::ICH_XFER: begin
          if (s_acc || (xfer_in && s_done)) begin
            if (xfer_in) begin
              word_reg <= s_data; // R15
            end
            state_reg <= ich_pkg::ICH_WAIT_LOW; // R7
          end
        end
        ich_pkg::ICH_WAIT_LOW: begin
          if (acks_low) begin
            state_reg <= ich_pkg::ICH_DONE; // R22
          end
        end
        ich_pkg::ICH_DONE: begin
          state_reg <= ich_pkg::ICH_IDLE;
        end
        default: begin
          state_reg <= ich_pkg::ICH_IDLE;
        end
      endcase
    end
  end

  // answer capture: flags latched while the request is open
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_accepted <= 1'b0;
      rsp_refused <= 1'b0;
      rsp_block_done <= 1'b0;
      rsp_parity_bad <= 1'b0;
      rsp_word <= ich_pkg::WORD_ZERO;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= (state_reg == ich_pkg::ICH_DONE) && !init_reg;
      if (req_ready) begin
        rsp_accepted <= 1'b0;
        rsp_refused <= 1'b0;
        rsp_block_done <= 1'b0;
        rsp_parity_bad <= 1'b0;
      end else if (state_reg == ich_pkg::ICH_SELECT || state_reg == ich_pkg::ICH_COMMAND) begin
        rsp_accepted <= s_acc && !s_ref;
        rsp_refused <= s_ref; // R17
      end else if (state_reg == ich_pkg::ICH_XFER && (s_acc || (xfer_in && s_done))) begin
        rsp_accepted <= s_acc;
        rsp_block_done <= xfer_in && s_done; // R18
        rsp_parity_bad <= xfer_in && s_acc && (word_bad || s_fail); // R3
        if (xfer_in) begin
          rsp_word <= s_data;
        end
      end
    end
  end

  // event set terms from the open handshake
  always_comb begin
    event_set = ich_pkg::EVT_NONE;
    if ((state_reg == ich_pkg::ICH_SELECT || state_reg == ich_pkg::ICH_COMMAND) && s_ref) begin
      event_set = event_set | ich_pkg::EVT_REFUSE;
    end
    if (state_reg == ich_pkg::ICH_XFER && xfer_in && s_done) begin
      event_set = event_set | ich_pkg::EVT_BLOCK_DONE;
    end
    if (state_reg == ich_pkg::ICH_XFER && s_acc && (s_fail || (xfer_in && word_bad))) begin
      event_set = event_set | ich_pkg::EVT_PARITY;
    end
  end

  // sticky events: set wins over clear
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      event_status <= ich_pkg::EVT_NONE;
    end else if (init_reg) begin
      event_status <= ich_pkg::EVT_NONE;
    end else begin
      event_status <= (event_status & ~event_clear) | event_set; // R23
    end
  end

  // pin drivers, all from flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= ich_pkg::WORD_ZERO;
      data_oe <= 1'b0;
      parity_out <= 1'b0;
      parity_oe <= 1'b0;
      read_level <= 1'b0;
      write_level <= 1'b0;
      select_unit_strobe <= 1'b0;
      command_strobe <= 1'b0;
      word_transfer_request <= 1'b0;
      channel_global_init <= 1'b1;
      host_active <= 1'b0;
    end else begin
      channel_global_init <= init_reg; // R10
      host_active <= computer_run; // R11
      data_out <= word_reg; // R1
      parity_out <= odd_bit(word_reg); // R3
      data_oe <= !init_reg && (op_reg != ich_pkg::ICH_OP_READ) && (state_reg != ich_pkg::ICH_IDLE); // R1
      parity_oe <= !init_reg && (op_reg != ich_pkg::ICH_OP_READ) && (state_reg != ich_pkg::ICH_IDLE);
      read_level <= !init_reg && (op_reg == ich_pkg::ICH_OP_READ) && (state_reg != ich_pkg::ICH_IDLE); // R4
      write_level <= !init_reg && (op_reg == ich_pkg::ICH_OP_WRITE) && (state_reg != ich_pkg::ICH_IDLE); // R4
      // codes go out one cycle ahead of their strobe so the lines have settled when it rises
      select_unit_strobe <= !init_reg && (state_reg == ich_pkg::ICH_SELECT) && data_oe && !s_acc && !s_ref; // R5
      command_strobe <= !init_reg && (state_reg == ich_pkg::ICH_COMMAND) && data_oe && !s_acc && !s_ref; // R6
      // output: data already on the lines one cycle earlier; input: room held in word_reg
      word_transfer_request <= !init_reg && (state_reg == ich_pkg::ICH_XFER) && data_oe == !xfer_in
        && !s_acc && !(xfer_in && s_done); // R7 R8 R9
    end
  end
endmodule

// *** src/ich_pkg.sv ***
// shared constants for the channel handshake block
package ich_pkg;
  localparam int DATA_W = 12;
  localparam int STAT_W = 12;
  localparam int MAX_UNITS = 8;
  localparam logic [11:0] WORD_ZERO = 12'h000;
  localparam logic [2:0] EVT_REFUSE = 3'h1;
  localparam logic [2:0] EVT_BLOCK_DONE = 3'h2;
  localparam logic [2:0] EVT_PARITY = 3'h4;
  localparam logic [2:0] EVT_NONE = 3'h0;
  typedef enum logic [2:0] {
    ICH_IDLE = 3'h0,
    ICH_SELECT = 3'h1,
    ICH_COMMAND = 3'h3,
    ICH_XFER = 3'h2,
    ICH_WAIT_LOW = 3'h6,
    ICH_DONE = 3'h7
  } ich_state_t;
  typedef enum logic [1:0] {
    ICH_OP_SELECT = 2'h0,
    ICH_OP_COMMAND = 2'h1,
    ICH_OP_READ = 2'h2,
    ICH_OP_WRITE = 2'h3
  } ich_op_t;
endpackage

// *** src/ich_sync.sv ***
// two-flop synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module ich_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk, // system clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic [WIDTH-1:0] async_in, // raw pin levels
  output logic [WIDTH-1:0] sync_out // synchronised levels
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// *** verification/ich_channel_chk.sv ***
// concurrent checks on the channel pins of the handshake block
`timescale 1ns/1ps
module ich_channel_chk #(
  parameter int DATA_W = ich_pkg::DATA_W
) (
  input wire logic ref_clk, // system clock
  input wire logic arst_n, // reset, active low
  input wire logic global_init_req, // init request from the user side
  input wire logic [DATA_W-1:0] data_out, // data lines to equipment
  input wire logic data_oe, // channel drives data lines
  input wire logic parity_out, // parity line to equipment
  input wire logic parity_oe, // channel drives parity line
  input wire logic read_level, // input operation level
  input wire logic write_level, // output operation level
  input wire logic select_unit_strobe, // unit-select strobe
  input wire logic command_strobe, // command strobe
  input wire logic word_transfer_request, // word transfer level
  input wire logic channel_global_init, // init level to equipment
  input wire logic accept_ack, // equipment accepts
  input wire logic refuse_ack // equipment refuses
);
  default clocking ck @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // an answer that has stood long enough to pass the two-flop synchroniser
  sequence sel_answered_s;
    (select_unit_strobe && (accept_ack || refuse_ack)) [*3];
  endsequence
  sequence cmd_answered_s;
    (command_strobe && (accept_ack || refuse_ack)) [*3];
  endsequence
  sequence wtr_accepted_s;
    (word_transfer_request && accept_ack) [*3];
  endsequence
  dir_exclusive_a: assert property (!(read_level && write_level)) else $error("read and write levels together");
  par_enable_a: assert property (parity_oe == data_oe) else $error("parity enable apart from data enable");
  xfer_dir_a: assert property (word_transfer_request |-> read_level || write_level)
    else $error("transfer level without a direction level");
  read_release_a: assert property (read_level |-> !data_oe) else $error("data driven during input");
  out_word_odd_a: assert property (word_transfer_request && write_level |-> data_oe && parity_out == ~^data_out)
    else $error("output word not valid with odd parity");
  code_steady_a: assert property (select_unit_strobe || command_strobe |-> data_oe && $stable(data_out))
    else $error("code not steady under strobe");
  one_request_a: assert property ($onehot0({select_unit_strobe, command_strobe, word_transfer_request}))
    else $error("two requests at once");
  sel_drop_a: assert property (sel_answered_s |=> !select_unit_strobe) else $error("select strobe held");
  cmd_drop_a: assert property (cmd_answered_s |=> !command_strobe) else $error("command strobe held");
  wtr_drop_a: assert property (wtr_accepted_s |=> !word_transfer_request) else $error("transfer level held");
  fresh_request_a: assert property ($rose(select_unit_strobe || command_strobe || word_transfer_request)
    |-> !accept_ack && !refuse_ack) else $error("request raised over a standing answer");
  init_zero_a: assert property (global_init_req [*4] |-> channel_global_init && !select_unit_strobe
    && !command_strobe && !word_transfer_request) else $error("init does not zero the channel");
endmodule
bind ich_channel ich_channel_chk #(.DATA_W(DATA_W)) ich_channel_chk_i (.ref_clk, .arst_n, .global_init_req,
  .data_out, .data_oe, .parity_out, .parity_oe, .read_level, .write_level, .select_unit_strobe, .command_strobe,
  .word_transfer_request, .channel_global_init, .accept_ack, .refuse_ack);

// *** verification/ich_equip.sv ***
// behavioural model of the peripheral equipment facing the channel
`timescale 1ns/1ps
module ich_equip (
  input wire logic ref_clk, // system clock
  input wire logic select_unit_strobe, // unit-select strobe
  input wire logic command_strobe, // command strobe
  input wire logic word_transfer_request, // word transfer level
  input wire logic read_level, // input operation level
  input wire logic channel_global_init, // init level, also the model's reset
  input wire logic [11:0] data_out, // data lines from channel
  input wire logic parity_out, // parity line from channel
  input wire logic [11:0] rd_word, // word to hand in on input
  input wire logic rej, // refuse select and command
  input wire logic eob, // end block on input
  input wire logic bad_par, // spoil the input parity
  output logic accept_ack, // accept answer
  output logic refuse_ack, // refuse answer
  output logic block_done_flag, // block end answer
  output logic odd_check_fail, // parity failure on a taken word
  output logic [11:0] data_in = 12'hA5C, // data lines to channel
  output logic parity_in = 1'h0, // parity line to channel
  output logic [11:0] wr_seen // last output word sampled
);
  logic [2:0] pause;
  // answers a request after a random pause and drops everything once it falls
  always @(posedge ref_clk) begin
    if (channel_global_init || !(select_unit_strobe || command_strobe || word_transfer_request)) begin
      {accept_ack, refuse_ack, block_done_flag, odd_check_fail} <= 4'h0;
      pause <= 3'($urandom);
      if (!accept_ack) begin
        data_in <= ~data_in; // released lines toggle every cycle after accept falls, so the old word never stands steady
        parity_in <= ~parity_in;
      end
    end else if (pause != 3'h0) begin
      pause <= pause - 3'h1;
    end else if (!(accept_ack || refuse_ack || block_done_flag)) begin
      if (!word_transfer_request && rej) begin
        refuse_ack <= 1'h1;
      end else if (word_transfer_request && read_level && eob) begin
        block_done_flag <= 1'h1;
      end else if (word_transfer_request && read_level) begin
        data_in <= rd_word;
        parity_in <= ~^rd_word ^ bad_par;
        accept_ack <= 1'h1;
      end else begin
        wr_seen <= data_out;
        odd_check_fail <= ~^{data_out, parity_out};
        accept_ack <= 1'h1;
      end
    end
  end
endmodule

// *** verification/io_channel_handshake_tb.sv ***
// self-checking bench: requests of every kind against the equipment model
`timescale 1ns/1ps
module io_channel_handshake_tb;
  typedef struct packed {logic rd; logic [3:0] f; logic [11:0] w;} ich_exp_t;
  logic ref_clk = 1'h0, arst_n = 1'h0, computer_run = 1'h0, global_init_req = 1'h0, req_valid = 1'h0;
  logic rej = 1'h0, eob = 1'h0, bad_par = 1'h0;
  logic [1:0] req_op = 2'h0;
  logic [2:0] event_clear = 3'h0;
  logic [7:0] irq_lines = 8'h00;
  logic [11:0] req_word = 12'h000, rd_word = 12'h000, status_lines = 12'h000, w;
  wire logic req_ready, rsp_valid, rsp_accepted, rsp_refused, rsp_block_done, rsp_parity_bad, data_oe, parity_in;
  wire logic parity_out, parity_oe, read_level, write_level, select_unit_strobe, command_strobe, word_transfer_request;
  wire logic channel_global_init, host_active, accept_ack, refuse_ack, block_done_flag, odd_check_fail;
  wire logic [2:0] event_status;
  wire logic [7:0] unit_irq;
  wire logic [11:0] rsp_word, unit_status, data_in, data_out, wr_seen;
  ich_exp_t exp_q[$];
  ich_exp_t e;
  int err_total = 0;
  int comparisons = 0;
  ich_channel ich_channel_i (.ref_clk, .arst_n, .computer_run, .global_init_req, .req_valid, .req_ready, .req_op,
    .req_word, .rsp_valid, .rsp_accepted, .rsp_refused, .rsp_block_done, .rsp_word, .rsp_parity_bad, .event_status,
    .event_clear, .unit_status, .unit_irq, .data_in, .data_out, .data_oe, .parity_in, .parity_out, .parity_oe,
    .read_level, .write_level, .select_unit_strobe, .command_strobe, .word_transfer_request, .channel_global_init,
    .host_active, .accept_ack, .refuse_ack, .block_done_flag, .odd_check_fail, .status_lines, .irq_lines);
  ich_equip equip_i (.ref_clk, .select_unit_strobe, .command_strobe, .word_transfer_request, .read_level,
    .channel_global_init, .data_out, .parity_out, .rd_word, .rej, .eob, .bad_par, .accept_ack, .refuse_ack,
    .block_done_flag, .odd_check_fail, .data_in, .parity_in, .wr_seen);
  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;
  task automatic complete_run;
    if (err_total == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [11:0] ex, input logic [11:0] got);
    comparisons++;
    if (got !== ex) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // one request held until taken, then wait for its answer to be checked
  task automatic xfer(input logic [1:0] op, input logic [11:0] wd, input logic rd, input logic [3:0] f,
    input logic [11:0] ew);
    int n;
    exp_q.push_back({rd, f, ew});
    req_op = op;
    req_word = wd;
    req_valid = 1'h1;
    #1;
    for (n = 0; req_ready !== 1'h1 && n < 500; n++) @(negedge ref_clk) #1;
    if (n >= 500) begin err_total++; complete_run(); end
    @(negedge ref_clk);
    req_valid = 1'h0;
    for (n = 0; exp_q.size() > 0 && n < 500; n++) @(negedge ref_clk);
    if (n >= 500) begin err_total++; complete_run(); end
  endtask
  // result watcher: oldest note against each answer pulse
  always @(negedge ref_clk) begin
    if (rsp_valid === 1'h1 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk("rsp_flags", {8'h00, e.f}, {8'h00, rsp_accepted, rsp_refused, rsp_block_done, rsp_parity_bad});
      if (e.rd) chk("rsp_word", e.w, rsp_word);
    end else if (rsp_valid === 1'h1) begin
      chk("rsp_unrequested", 12'h000, 12'h001);
    end
  end
  // main sequence
  initial begin
    int i;
    void'($urandom(32'h3E52));
    repeat (6) @(negedge ref_clk);
    arst_n = 1'h1;
    computer_run = 1'h1;
    repeat (3) @(negedge ref_clk);
    chk("host_active", 12'h001, {11'h000, host_active});
    xfer(2'h0, 12'h5A3, 1'h0, 4'h8, 12'h000);
    rej = 1'h1;
    xfer(2'h0, 12'h011, 1'h0, 4'h4, 12'h000);
    xfer(2'h1, 12'hF0E, 1'h0, 4'h4, 12'h000);
    chk("event_status", 12'h001, {9'h000, event_status});
    event_clear = 3'h7;
    @(negedge ref_clk);
    event_clear = 3'h0;
    chk("event_status", 12'h000, {9'h000, event_status});
    rej = 1'h0;
    xfer(2'h1, 12'h7FF, 1'h0, 4'h8, 12'h000);
    for (i = 0; i < 6; i++) begin
      w = 12'($urandom);
      rd_word = 12'($urandom);
      xfer(2'h3, w, 1'h0, 4'h8, 12'h000);
      chk("wr_seen", w, wr_seen);
      xfer(2'h2, 12'h000, 1'h1, 4'h8, rd_word);
    end
    bad_par = 1'h1;
    xfer(2'h2, 12'h000, 1'h1, 4'h9, rd_word);
    bad_par = 1'h0;
    eob = 1'h1;
    xfer(2'h2, 12'h000, 1'h0, 4'h2, 12'h000);
    eob = 1'h0;
    chk("event_status", 12'h006, {9'h000, event_status});
    status_lines = 12'($urandom);
    irq_lines = 8'($urandom);
    repeat (4) @(negedge ref_clk);
    chk("unit_status", status_lines, unit_status);
    chk("unit_irq", {4'h0, irq_lines}, {4'h0, unit_irq});
    global_init_req = 1'h1;
    repeat (4) @(negedge ref_clk);
    chk("channel_global_init", 12'h001, {11'h000, channel_global_init});
    chk("event_status", 12'h000, {9'h000, event_status});
    global_init_req = 1'h0;
    computer_run = 1'h0;
    repeat (3) @(negedge ref_clk);
    chk("host_active", 12'h000, {11'h000, host_active});
    complete_run();
  end
endmodule
